// file: include/eip_pkg.sv
// Package for the extended interrupt priority register block.
// Assumes an 8-bit special-function-register bus on one clock.
package eip_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EIP_PRIO1_ADDR = 8'hF6;
  localparam logic [7:0] EIP_PRIO1_RST = 8'h00;
  localparam int EIP_NUM_SRC = 8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EIP_BIT_TIMER_C = 7;
  localparam int EIP_BIT_COMP_B = 6;
  localparam int EIP_BIT_COMP_A = 5;
  localparam int EIP_BIT_COUNTER_ARRAY = 4;
  localparam int EIP_BIT_CONV_DONE = 3;
  localparam int EIP_BIT_CONV_WINDOW = 2;
  localparam int EIP_BIT_RTC_ALARM = 1;
  localparam int EIP_BIT_SMBUS = 0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timer_c_irq_high_prio;
    logic comparator_b_irq_high_prio;
    logic comparator_a_irq_high_prio;
    logic counter_array_irq_high_prio;
    logic conv_done_irq_high_prio;
    logic conv_window_irq_high_prio;
    logic rtc_alarm_irq_high_prio;
    logic smbus_irq_high_prio;
  } eip_prio_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eip_sfr_req_t;

  typedef enum logic [1:0] {
    EIP_LVL_IDLE = 2'b00,
    EIP_LVL_LOW = 2'b01,
    EIP_LVL_HIGH = 2'b10
  } eip_level_t;

endpackage

// file: hw/eip_prio_ctrl.sv
// Priority register and two-level interrupt arbitration.
// Assumes the core presents SFR requests synchronous to clk and
// flags each return from an interrupt routine with a one-cycle pulse.
//
// Operation
// - The register answers at address 0xF6 on every page, all bits RW, zero on reset.
// - Bit 7 makes the timer C interrupt high priority when set.
// - Bit 6 makes the comparator B interrupt high priority when set.
// - Bit 5 makes the comparator A interrupt high priority when set.
// - Bit 4 makes the counter array interrupt high priority when set.
// - Bit 3 makes the conversion-done interrupt high priority when set.
// - Bit 2 makes the converter window interrupt high priority when set.
// - Bit 1 makes the RTC alarm interrupt high priority when set.
// - Bit 0 makes the SMBus interrupt high priority when set.
`timescale 1ns/100ps

module eip_prio_ctrl
  import eip_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire eip_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [EIP_NUM_SRC-1:0] irq_pend,
  input wire logic irq_ack,
  input wire logic irq_ret,
  output logic irq_req,
  output logic [2:0] irq_src,
  output logic irq_high,
  output eip_prio_t prio,
  output eip_level_t active_level
);

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  logic [7:0] extended_irq_priority_1_r;
  logic [7:0] sfr_rdata_r;

  // Page select is ignored: the register lives on all pages
  assign sfr_hit = (sfr_req.addr == EIP_PRIO1_ADDR);

  always_ff @(posedge clk) begin
    if (srst) begin
      extended_irq_priority_1_r <= EIP_PRIO1_RST;
    end else if (sfr_req.wr && sfr_hit) begin
      extended_irq_priority_1_r <= sfr_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_req.rd && sfr_hit) begin
      sfr_rdata_r <= extended_irq_priority_1_r;
    end else begin
      sfr_rdata_r <= 8'h00;
    end
  end

  assign sfr_rdata = sfr_rdata_r;

  // ----------------------------------------------------------------
  // Field view
  // ----------------------------------------------------------------
  assign prio.timer_c_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_TIMER_C];
  assign prio.comparator_b_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_COMP_B];
  assign prio.comparator_a_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_COMP_A];
  assign prio.counter_array_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_COUNTER_ARRAY];
  assign prio.conv_done_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_CONV_DONE];
  assign prio.conv_window_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_CONV_WINDOW];
  assign prio.rtc_alarm_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_RTC_ALARM];
  assign prio.smbus_irq_high_prio =
    extended_irq_priority_1_r[EIP_BIT_SMBUS];

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [EIP_NUM_SRC-1:0] hi_pend;
  logic [EIP_NUM_SRC-1:0] lo_pend;
  logic [2:0] hi_idx;
  logic [2:0] lo_idx;
  logic hi_any;
  logic lo_any;
  logic nest_low_r;
  eip_level_t level_r;

  genvar g;
  generate
    for (g = 0; g < EIP_NUM_SRC; g++) begin : g_split
      // Each bit routes its source to one of two levels
      assign hi_pend[g] = irq_pend[g] & extended_irq_priority_1_r[g];
      assign lo_pend[g] = irq_pend[g] & ~extended_irq_priority_1_r[g];
    end
  endgenerate

  // Lowest index wins within a level, fixed order
  always_comb begin
    hi_idx = 3'h0;
    lo_idx = 3'h0;
    for (int i = EIP_NUM_SRC - 1; i >= 0; i--) begin
      if (hi_pend[i]) begin
        hi_idx = 3'(i);
      end
      if (lo_pend[i]) begin
        lo_idx = 3'(i);
      end
    end
  end

  assign hi_any = |hi_pend;
  assign lo_any = |lo_pend;

  always_comb begin
    irq_req = 1'b0;
    irq_src = 3'h0;
    irq_high = 1'b0;
    case (level_r)
      EIP_LVL_IDLE: begin
        irq_req = hi_any | lo_any;
        irq_src = hi_any ? hi_idx : lo_idx;
        irq_high = hi_any;
      end
      EIP_LVL_LOW: begin
        irq_req = hi_any;
        irq_src = hi_idx;
        irq_high = hi_any;
      end
      EIP_LVL_HIGH: begin
        irq_req = 1'b0;
      end
      default: begin
        irq_req = 1'b0;
      end
    endcase
  end

  // One level of nesting only, so one bit remembers the low routine
  always_ff @(posedge clk) begin
    if (srst) begin
      level_r <= EIP_LVL_IDLE;
      nest_low_r <= 1'b0;
    end else if (irq_ack && irq_req) begin
      level_r <= irq_high ? EIP_LVL_HIGH : EIP_LVL_LOW;
      nest_low_r <= (level_r == EIP_LVL_LOW);
    end else if (irq_ret) begin
      case (level_r)
        EIP_LVL_HIGH: begin
          level_r <= nest_low_r ? EIP_LVL_LOW : EIP_LVL_IDLE;
          nest_low_r <= 1'b0;
        end
        default: begin
          level_r <= EIP_LVL_IDLE;
        end
      endcase
    end
  end

  assign active_level = level_r;

endmodule // eip_prio_ctrl

// file: testbench/eip_sva.sv
// Checker on the priority block ports.
// Bound to eip_prio_ctrl; one clock, reset srst.
`timescale 1ns/100ps
module eip_sva
  import eip_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire eip_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic [EIP_NUM_SRC-1:0] irq_pend,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [2:0] irq_src,
  input wire logic irq_high,
  input wire eip_prio_t prio,
  input wire eip_level_t active_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire wr_hit = sfr_req.wr && sfr_req.addr == EIP_PRIO1_ADDR;
  wire rd_hit = sfr_req.rd && sfr_req.addr == EIP_PRIO1_ADDR;
  wr_data_a: assert property (
    wr_hit |=> prio == $past(sfr_req.wdata)) else $error("write lost");
  reg_hold_a: assert property (
    !wr_hit |=> $stable(prio)) else $error("register moved");
  rd_data_a: assert property (
    rd_hit |=> sfr_rdata == $past(prio)) else $error("read wrong");
  rd_idle_a: assert property (
    !rd_hit |=> sfr_rdata == 8'h00) else $error("read not zero");
  high_map_a: assert property ( // to
    irq_req |-> irq_high == prio[irq_src]) else $error("level map");
  src_pend_a: assert property (
    irq_req |-> irq_pend[irq_src]) else $error("source idle");
  high_mask_a: assert property (
    active_level == EIP_LVL_HIGH |-> !irq_req) else $error("nested high");
  low_mask_a: assert property (
    irq_req && active_level == EIP_LVL_LOW |-> irq_high) else $error("low");
  high_nest_a: assert property (
    irq_ack && irq_req && irq_high |=> active_level == EIP_LVL_HIGH)
    else $error("no high level");
  cover property (wr_hit);
  cover property (active_level == EIP_LVL_HIGH);
  cover property (irq_ack && !irq_high);
endmodule // eip_sva

bind eip_prio_ctrl eip_sva chk (.clk(clk), .srst(srst), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .irq_pend(irq_pend), .irq_ack(irq_ack),
  .irq_req(irq_req), .irq_src(irq_src), .irq_high(irq_high),
  .prio(prio), .active_level(active_level));

// file: testbench/eip_core_model.sv
// Core model that takes offered interrupts.
// Assumes take is driven off the falling edge.
`timescale 1ns/100ps
module eip_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic take,
  output logic irq_ack
);
  // Gap after each ack so one request is never taken twice
  always_ff @(posedge clk) begin
    irq_ack <= !srst && take && irq_req && !irq_ack;
  end
endmodule // eip_core_model

// file: testbench/eip_prio_ctrl_tb.sv
// Self-checking bench for the priority block.
// Assumes a 200 MHz clock and the core model.
`timescale 1ns/100ps
module eip_prio_ctrl_tb;
  import eip_pkg::*;
  logic clk = 0, srst = 1, irq_ret = 0, take = 0, irq_ack, sfr_hit;
  logic irq_req, irq_high;
  eip_sfr_req_t sfr_req = '0;
  logic [7:0] irq_pend = 8'h00, sfr_rdata, d;
  logic [2:0] irq_src;
  eip_prio_t prio;
  eip_level_t active_level;
  int miscompares = 0, total_checks = 0, seed = 13;
  eip_prio_ctrl dut (.clk(clk), .srst(srst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .irq_pend(irq_pend),
    .irq_ack(irq_ack), .irq_ret(irq_ret), .irq_req(irq_req),
    .irq_src(irq_src), .irq_high(irq_high), .prio(prio),
    .active_level(active_level));
  eip_core_model core (.clk(clk), .srst(srst), .irq_req(irq_req),
    .take(take), .irq_ack(irq_ack));
  initial forever #2.5 clk = ~clk;
  function automatic logic hi(logic [7:0] p, int n);
    return p[n];
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Read strobe uses v as the expected byte
  task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
    @(negedge clk);
    sfr_req = '{wr: w, rd: !w, addr: a, wdata: v};
    #1 chk("hit", a == 8'hF6, sfr_hit);
    @(negedge clk);
    sfr_req = '0;
    if (!w) chk("rdata", (a == 8'hF6) ? v : 8'h00, sfr_rdata);
  endtask
  task automatic lvl(eip_level_t l);
    int i;
    for (i = 0; i < 20 && active_level !== l; i++) @(negedge clk);
    chk("level", l, active_level);
    if (i == 20) close_out();
  endtask
  initial begin
    repeat (2) @(negedge clk);
    srst = 0;
    acc(0, 8'hF6, 8'h00);
    for (int n = 0; n < 8; n++) begin
      d = $random(seed);
      acc(1, 8'hF6, d);
      irq_pend = 8'h01 << n;
      #1 chk("high", hi(d, n), irq_high); // to
      chk("src", n, irq_src); // to
      irq_pend = 8'h00;
    end
    $display("test bit map done");
    repeat (20) begin
      d = $random(seed);
      acc(1, 8'hF6, d);
      acc(1, d ^ 8'hF6 | 8'h01, ~d);
      acc(0, 8'hF6, d);
      acc(0, 8'hF5, d);
    end
    $display("test access done");
    acc(1, 8'hF6, 8'h80);
    irq_pend = 8'h01;
    take = 1;
    lvl(EIP_LVL_LOW);
    irq_pend = 8'h81;
    lvl(EIP_LVL_HIGH);
    repeat (3) @(negedge clk) chk("req", 8'h00, irq_req);
    take = 0;
    irq_pend = 8'h00;
    repeat (2) begin
      irq_ret = 1;
      @(negedge clk) irq_ret = 0;
      @(negedge clk);
    end
    lvl(EIP_LVL_IDLE);
    $display("test nesting done");
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    chk("prio", 8'h00, prio);
    $display("test reset done");
    close_out();
  end
endmodule // eip_prio_ctrl_tb
